// file: fsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module fsc_host #(
	parameter int PROTECT_WAIT_CYC = fsc_pkg::PROT_WAIT_CYC
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              resetn_i,
	// User side
	input  wire logic              req_valid_i,
	input  wire fsc_pkg::fsc_req_t req_i,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   refused_o,
	output logic                   fail_o,
	output logic [15:0]            rd_data_o,
	output fsc_pkg::fsc_mode_t     mode_o,
	// Flash pins
	output fsc_pkg::fsc_pins_t     flash_o,
	input  wire logic [15:0]       dq_i
);
	typedef enum logic [4:0] {
		S_IDLE = 5'h01, S_FETCH = 5'h02, S_WR = 5'h04, S_RD = 5'h08, S_WAIT = 5'h10
	} fsc_state_t;

	fsc_state_t         st;
	fsc_pkg::fsc_op_t   cur_op;
	logic [21:0]        cur_addr;
	logic [15:0]        cur_data;
	logic [2:0]         idx;
	logic [7:0]         cnt;
	logic [15:0]        wcnt;
	logic [4:0]         tries;
	logic [15:0]        dq_s1;
	logic [15:0]        dq_s2;
	fsc_pkg::fsc_pins_t next_pins;

	function automatic fsc_pkg::fsc_step_t mk(fsc_pkg::fsc_kind_t k, logic [21:0] a,
		logic [15:0] d);
		mk = '{kind: k, addr: a, data: d};
	endfunction

	// Unlock pair followed by a third write at the first unlock address
	function automatic fsc_pkg::fsc_step_t unl(logic [2:0] i, logic [15:0] c);
		case (i)
		3'd0: unl = mk(fsc_pkg::K_WR, fsc_pkg::A_UNLK1, fsc_pkg::C_UNLK1);
		3'd1: unl = mk(fsc_pkg::K_WR, fsc_pkg::A_UNLK2, fsc_pkg::C_UNLK2);
		default: unl = mk(fsc_pkg::K_WR, fsc_pkg::A_UNLK1, c);
		endcase
	endfunction

	function automatic fsc_pkg::fsc_step_t step_of(fsc_pkg::fsc_op_t op, logic [2:0] i,
		logic [21:0] a, logic [15:0] d);
		logic [21:0] g;
		g = {a[21:7], 1'b0, a[5:4], 4'h2};
		step_of = mk(fsc_pkg::K_END, a, d);
		case (op)
		fsc_pkg::OP_READ:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_RD, a, d);
		fsc_pkg::OP_PROGRAM, fsc_pkg::OP_OTP_PROG:
			if (i < 3'd3) step_of = unl(i, fsc_pkg::C_PROG);
			else if (i == 3'd3) step_of = mk(fsc_pkg::K_WR, a, d);
			else if (i == 3'd4) step_of = mk(fsc_pkg::K_POLL, a, d);
		fsc_pkg::OP_SUSPEND:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_SUSP);
			else if (i == 3'd1) step_of = mk(fsc_pkg::K_WAIT, a, d);
			else if (i == 3'd2) step_of = mk(fsc_pkg::K_POLL, a, fsc_pkg::C_POLL1);
		fsc_pkg::OP_RESUME:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_RESUM);
		fsc_pkg::OP_FAST_ENTER:
			if (i < 3'd3) step_of = unl(i, fsc_pkg::C_FAST);
		fsc_pkg::OP_FAST_PROG:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_PROG);
			else if (i == 3'd1) step_of = mk(fsc_pkg::K_WR, a, d);
			else if (i == 3'd2) step_of = mk(fsc_pkg::K_POLL, a, d);
		fsc_pkg::OP_FAST_EXIT:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_FRST1);
			else if (i == 3'd1) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_FRST2);
		fsc_pkg::OP_PROTECT:
			if (i < 3'd2) step_of = mk(fsc_pkg::K_WR, g, fsc_pkg::C_GPROT);
			else if (i == 3'd2) step_of = mk(fsc_pkg::K_WAIT, g, d);
			else if (i == 3'd3) step_of = mk(fsc_pkg::K_WR, g, fsc_pkg::C_GVER);
			else if (i == 3'd4) step_of = mk(fsc_pkg::K_VERIFY, g, d);
		fsc_pkg::OP_QUERY:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, fsc_pkg::A_QUERY, fsc_pkg::C_QUERY);
		fsc_pkg::OP_RESET:
			if (i == 3'd0) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_RESET);
		fsc_pkg::OP_OTP_ENTER:
			if (i < 3'd3) step_of = unl(i, fsc_pkg::C_OTPIN);
		fsc_pkg::OP_OTP_EXIT:
			if (i < 3'd3) step_of = unl(i, fsc_pkg::C_OTPX1);
			else if (i == 3'd3) step_of = mk(fsc_pkg::K_WR, a, fsc_pkg::C_OTPX2);
		default:
			step_of = mk(fsc_pkg::K_END, a, d);
		endcase
	endfunction

	// Host side guard: what each mode lets through
	function automatic logic allowed(fsc_pkg::fsc_op_t op, fsc_pkg::fsc_mode_t m);
		allowed = 1'b1;
		if (op == fsc_pkg::OP_READ) allowed = 1'b1;
		else if (m.fast) allowed = (op == fsc_pkg::OP_FAST_PROG) ||
			(op == fsc_pkg::OP_FAST_EXIT);
		else if (m.otp) allowed = (op == fsc_pkg::OP_OTP_PROG) ||
			(op == fsc_pkg::OP_OTP_EXIT);
		else if (m.query) allowed = (op == fsc_pkg::OP_RESET);
		else if (m.susp) allowed = (op == fsc_pkg::OP_RESUME) ||
			(op == fsc_pkg::OP_SUSPEND);
		else allowed = (op != fsc_pkg::OP_RESUME) && (op != fsc_pkg::OP_FAST_PROG) &&
			(op != fsc_pkg::OP_FAST_EXIT) && (op != fsc_pkg::OP_OTP_PROG) &&
			(op != fsc_pkg::OP_OTP_EXIT);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire fsc_pkg::fsc_step_t stp    = step_of(cur_op, idx, cur_addr, cur_data);
	wire                     take   = req_valid_i && !busy_o;
	wire                     ok     = allowed(req_i.op, mode_o);
	wire                     wr_end = (st == S_WR) && (cnt == 8'(fsc_pkg::WP_CYC + 1));
	wire                     rd_end = (st == S_RD) && (cnt == 8'(fsc_pkg::RD_CYC - 1));
	wire                     we_on  = (st == S_WR) && (cnt != 8'd0) &&
		(cnt <= 8'(fsc_pkg::WP_CYC));
	wire                     fin    = (st == S_FETCH) && (stp.kind == fsc_pkg::K_END);
	wire                     pass   = (stp.kind == fsc_pkg::K_POLL) ?
		(dq_s2[7] == stp.data[7]) : (stp.kind != fsc_pkg::K_VERIFY) || dq_s2[0];
	wire                     retry  = !pass && (stp.kind == fsc_pkg::K_VERIFY) &&
		(tries < 5'(fsc_pkg::PROT_TRIES - 1));

	always_comb begin
		next_pins         = flash_o;
		next_pins.ce_n    = !((st == S_WR) || (st == S_RD));
		next_pins.oe_n    = !(st == S_RD);
		next_pins.we_n    = !we_on;
		next_pins.dq_oe_n = !(st == S_WR);
		next_pins.addr    = stp.addr;
		next_pins.dq      = stp.data;
		// Reset pin returns to logic high once protection ends
		next_pins.vid_en  = (take && ok && (req_i.op == fsc_pkg::OP_PROTECT)) ||
			(flash_o.vid_en && !fin);
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
			flash_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0,
				dq_oe_n: 1'b1, vid_en: 1'b0};
		end else begin
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
			flash_o <= next_pins;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= S_IDLE;
			cur_op <= fsc_pkg::OP_READ;
			cur_addr <= 22'h000000;
			cur_data <= 16'h0000;
			idx <= 3'd0;
			cnt <= 8'h00;
			wcnt <= 16'h0000;
			tries <= 5'h00;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			refused_o <= 1'b0;
			fail_o <= 1'b0;
			rd_data_o <= 16'h0000;
			mode_o <= '0;
		end else begin
			done_o <= fin || (take && !ok);
			refused_o <= take && !ok;
			cnt <= cnt + 8'h01;
			case (st)
			S_IDLE: begin
				if (take && ok) begin
					cur_op <= req_i.op;
					cur_addr <= req_i.addr;
					cur_data <= req_i.data;
					idx <= 3'd0;
					tries <= 5'h00;
					fail_o <= 1'b0;
					busy_o <= 1'b1;
					st <= S_FETCH;
				end
			end
			S_FETCH: begin
				cnt <= 8'h00;
				wcnt <= (cur_op == fsc_pkg::OP_PROTECT) ? 16'(PROTECT_WAIT_CYC - 1) :
					16'(fsc_pkg::SUSP_WAIT_CYC - 1);
				case (stp.kind)
				fsc_pkg::K_WR:   st <= S_WR;
				fsc_pkg::K_WAIT: st <= S_WAIT;
				fsc_pkg::K_END: begin
					busy_o <= 1'b0;
					st <= S_IDLE;
					case (cur_op)
					fsc_pkg::OP_SUSPEND:    mode_o.susp <= 1'b1;
					fsc_pkg::OP_RESUME:     mode_o.susp <= 1'b0;
					fsc_pkg::OP_FAST_ENTER: mode_o.fast <= 1'b1;
					fsc_pkg::OP_FAST_EXIT:  mode_o.fast <= 1'b0;
					fsc_pkg::OP_QUERY:      mode_o.query <= 1'b1;
					fsc_pkg::OP_RESET:      mode_o.query <= 1'b0;
					fsc_pkg::OP_OTP_ENTER:  mode_o.otp <= 1'b1;
					fsc_pkg::OP_OTP_EXIT:   mode_o.otp <= 1'b0;
					default:                mode_o <= mode_o;
					endcase
				end
				default: st <= S_RD;
				endcase
			end
			S_WR: begin
				if (wr_end) begin
					idx <= idx + 3'd1;
					st <= S_FETCH;
				end
			end
			S_RD: begin
				if (rd_end) begin
					rd_data_o <= dq_s2;
					st <= S_FETCH;
					if (retry) begin
						tries <= tries + 5'h01;
						idx <= 3'd1;
					end else if (pass || (stp.kind == fsc_pkg::K_VERIFY)) begin
						fail_o <= !pass;
						idx <= idx + 3'd1;
					end
				end
			end
			S_WAIT: begin
				wcnt <= wcnt - 16'h0001;
				if (wcnt == 16'h0000) begin
					idx <= idx + 3'd1;
					st <= S_FETCH;
				end
			end
			default: st <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_susp_noprog;
		mode_o.susp && take && (req_i.op == fsc_pkg::OP_PROGRAM) |=> refused_o && !busy_o;
	endproperty
	a_susp_noprog: assert property (p_susp_noprog) else $error("program while suspended");

	property p_fast_only;
		mode_o.fast && $rose(busy_o) |-> (cur_op == fsc_pkg::OP_FAST_PROG) ||
			(cur_op == fsc_pkg::OP_FAST_EXIT) || (cur_op == fsc_pkg::OP_READ);
	endproperty
	a_fast_only: assert property (p_fast_only) else $error("illegal op in fast mode");

	property p_otp_only;
		mode_o.otp && $rose(busy_o) |-> (cur_op == fsc_pkg::OP_OTP_PROG) ||
			(cur_op == fsc_pkg::OP_OTP_EXIT) || (cur_op == fsc_pkg::OP_READ);
	endproperty
	a_otp_only: assert property (p_otp_only) else $error("illegal op in secure mode");

	property p_query_exit;
		$fell(mode_o.query) |-> $past(cur_op) == fsc_pkg::OP_RESET && $past(fin);
	endproperty
	a_query_exit: assert property (p_query_exit) else $error("query left without reset");

	property p_grp_pattern;
		!flash_o.we_n && (cur_op == fsc_pkg::OP_PROTECT) |-> flash_o.vid_en &&
			!flash_o.addr[6] && (flash_o.addr[3:0] == 4'h2);
	endproperty
	a_grp_pattern: assert property (p_grp_pattern) else $error("bad group write");

	property p_vid_drop;
		fin && (cur_op == fsc_pkg::OP_PROTECT) |=> !flash_o.vid_en ##1 !flash_o.vid_en;
	endproperty
	a_vid_drop: assert property (p_vid_drop) else $error("high voltage not removed");

	property p_retry;
		rd_end && (stp.kind == fsc_pkg::K_VERIFY) && !dq_s2[0] && retry |=>
			(idx == 3'd1) ##1 (st == S_WR);
	endproperty
	a_retry: assert property (p_retry) else $error("protect not repeated");

	property p_fast_two;
		(cur_op == fsc_pkg::OP_FAST_PROG) && (st == S_WR) |-> (idx <= 3'd1) &&
			(stp.addr == cur_addr);
	endproperty
	a_fast_two: assert property (p_fast_two) else $error("fast program not two cycles");

	property p_susp_addr;
		(cur_op == fsc_pkg::OP_SUSPEND) && (st == S_RD) |=> flash_o.addr == cur_addr;
	endproperty
	a_susp_addr: assert property (p_susp_addr) else $error("status read off sector");
endmodule
`default_nettype wire

// file: fsc_pkg.sv
// Contract
// - Host checks suspension by reading status at an erasing-sector address.
// - Host issues no program sequence while erase is suspended.
// - Fast mode programs with A0h then one address/data write, no unlocks.
// - In fast mode host writes only fast program or fast mode reset.
// - High voltage on reset pin, 60h then 60h at group pattern protects.
// - Verify 40h then read; bit 0 one means protected, else repeat.
// - Host ends group protection by returning reset pin to logic high.
// - Host leaves query mode by the read/reset command.
// - In secure mode host issues only secure program, protect or exit; the host guard refuses protect there, allowing secure program, exit and read.
// - Secure programming uses ordinary program and polling; no program suspend.
`default_nettype none
package fsc_pkg;
	localparam int CLK_NS = 20;
	// ----------------------------------------
	// Bus timing
	// ----------------------------------------
	localparam int T_WP_NS       = 60;
	localparam int T_RD_NS       = 100;
	localparam int T_SUSP_US     = 20;
	localparam int T_PROT_US     = 250;
	localparam int WP_CYC        = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	// Three extra cycles cover the pin register and the data synchroniser
	localparam int RD_CYC        = (T_RD_NS + CLK_NS - 1) / CLK_NS + 3;
	localparam int SUSP_WAIT_CYC = T_SUSP_US * 1000 / CLK_NS;
	localparam int PROT_WAIT_CYC = T_PROT_US * 1000 / CLK_NS;
	localparam int PROT_TRIES    = 25;
	// ----------------------------------------
	// Codes and addresses
	// ----------------------------------------
	localparam logic [15:0] C_UNLK1 = 16'h00aa;
	localparam logic [15:0] C_UNLK2 = 16'h0055;
	localparam logic [15:0] C_SUSP  = 16'h00b0;
	localparam logic [15:0] C_RESUM = 16'h0030;
	localparam logic [15:0] C_PROG  = 16'h00a0;
	localparam logic [15:0] C_FAST  = 16'h0020;
	localparam logic [15:0] C_FRST1 = 16'h0090;
	localparam logic [15:0] C_FRST2 = 16'h0000;
	localparam logic [15:0] C_GPROT = 16'h0060;
	localparam logic [15:0] C_GVER  = 16'h0040;
	localparam logic [15:0] C_QUERY = 16'h0098;
	localparam logic [15:0] C_RESET = 16'h00f0;
	localparam logic [15:0] C_OTPIN = 16'h0088;
	localparam logic [15:0] C_OTPX1 = 16'h0090;
	localparam logic [15:0] C_OTPX2 = 16'h0000;
	localparam logic [15:0] C_POLL1 = 16'h0080;
	localparam logic [21:0] A_UNLK1 = 22'h000555;
	localparam logic [21:0] A_UNLK2 = 22'h0002aa;
	localparam logic [21:0] A_QUERY = 22'h000055;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_FAST_ENTER, OP_FAST_PROG,
		OP_FAST_EXIT, OP_PROTECT, OP_QUERY, OP_RESET, OP_OTP_ENTER, OP_OTP_EXIT,
		OP_OTP_PROG
	} fsc_op_t;
	typedef enum logic [2:0] {K_END, K_WR, K_RD, K_POLL, K_VERIFY, K_WAIT} fsc_kind_t;
	typedef struct packed {
		fsc_op_t     op;
		logic [21:0] addr;
		logic [15:0] data;
	} fsc_req_t;
	typedef struct packed {
		fsc_kind_t   kind;
		logic [21:0] addr;
		logic [15:0] data;
	} fsc_step_t;
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [21:0] addr;
		logic [15:0] dq;
		logic        dq_oe_n;
		logic        vid_en;
	} fsc_pins_t;
	typedef struct packed {
		logic susp;
		logic fast;
		logic query;
		logic otp;
	} fsc_mode_t;
endpackage
`default_nettype wire

// file: fsc_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module fsc_flash_model #(
	parameter logic [6:0] ERASE_SEC = 7'h05,
	parameter logic [4:0] HARD_GRP  = 5'h07
) (
	// Bus pins
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        vid_en_i,
	input  wire logic [21:0] addr_i,
	input  wire logic [15:0] dq_i,
	// Scenario control
	input  wire logic        erase_go_i,
	output logic      [15:0] dq_o
);
	logic [15:0] mem [logic [22:0]];
	logic [31:0] prot = '0;
	logic        susp = 0, fast = 0, otp = 0, query = 0;
	logic        pg = 0, arm = 0, ver = 0, xit = 0, t2 = 0, t6 = 0;
	logic        tried = 0, otp_lock = 0;
	logic [1:0]  ul = 0;
	logic [15:0] v, last = '0;
	wire logic [22:0] key = {otp && addr_i[21:7] == 15'h0, addr_i};
	wire logic        in_es = erase_go_i && addr_i[21:15] == ERASE_SEC;

	always @* begin
		if (ver) v = {15'h0, prot[addr_i[21:17]]};
		else if (query) v = {8'h00, addr_i[7:0] ^ 8'h51};
		else if (in_es && susp) v = {8'h00, 2'b11, 3'b000, t2, 2'b00};
		else if (in_es) v = {8'h00, 1'b0, t6, 6'h08};
		else if (mem.exists(key)) v = mem[key];
		else v = key[15:0] ^ (key[22] ? 16'hc3c3 : 16'h5a5a);
	end
	// Released bus shows the inverse so a stale sample cannot pass
	assign dq_o = (!ce_n_i && !oe_n_i) ? v : ~last;
	always @(posedge oe_n_i) last = v;
	always @(negedge oe_n_i) if (!ce_n_i) begin
		t6 = (in_es && !susp) ? ~t6 : t6;
		t2 = in_es ? ~t2 : t2;
	end
	always @(negedge vid_en_i) {arm, ver} = '0;
	always @(posedge we_n_i) if (!ce_n_i) begin
		if (pg) begin
			// A locked secure region keeps its words
			if (!(key[22] && otp_lock)) mem[key] = dq_i;
			pg = 0;
		end else if (vid_en_i) begin
			ver = dq_i == 16'h0040;
			// One group needs a second pulse so the repeat path runs
			if (dq_i == 16'h0060 && arm && !addr_i[6] && addr_i[3:0] == 4'h2) begin
				prot[addr_i[21:17]] = addr_i[21:17] != HARD_GRP || tried;
				tried = tried || addr_i[21:17] == HARD_GRP;
			end
			arm = arm || dq_i == 16'h0060;
		end else if (ul == 2) begin
			ul = 0;
			pg = dq_i == 16'h00a0;
			fast = fast || dq_i == 16'h0020;
			otp = otp || dq_i == 16'h0088;
			xit = dq_i == 16'h0090;
		end else if (dq_i == 16'h00aa && addr_i == 22'h000555) ul = 1;
		else if (ul == 1 && dq_i == 16'h0055 && addr_i == 22'h0002aa) ul = 2;
		else if (xit && dq_i == 16'h0000) {fast, otp, xit} = '0;
		else if (fast) begin
			pg = dq_i == 16'h00a0;
			xit = dq_i == 16'h0090;
		end else if (dq_i == 16'h00b0) susp = susp || erase_go_i;
		else if (dq_i == 16'h0030) susp = 0;
		else if (dq_i == 16'h0098) query = 1;
		else if (dq_i == 16'h00f0) query = 0;
	end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam logic [21:0] ES_A = 22'h028010;
	logic               clk_sys = 0;
	logic               resetn = 0;
	logic               req_valid = 0;
	logic               erase_go = 0;
	fsc_pkg::fsc_req_t  req = '0;
	logic               busy, done, refused, fail;
	logic [15:0]        rd_data, s1;
	fsc_pkg::fsc_mode_t mode;
	fsc_pkg::fsc_pins_t pins;
	wire logic [15:0]   dev_dq;
	wire logic [15:0]   dq_bus = pins.dq_oe_n ? dev_dq : pins.dq;
	wire logic [4:0]    ctl_pins = {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n, pins.vid_en};
	int                 err_total = 0;
	int                 num_checks = 0;
	int                 n_wr = 0;
	int                 w0;

	fsc_host #(.PROTECT_WAIT_CYC(20)) dut_u (.clk_sys_i(clk_sys), .resetn_i(resetn),
		.req_valid_i(req_valid), .req_i(req), .busy_o(busy), .done_o(done),
		.refused_o(refused), .fail_o(fail), .rd_data_o(rd_data), .mode_o(mode),
		.flash_o(pins), .dq_i(dq_bus));
	fsc_flash_model dev_u (.ce_n_i(pins.ce_n), .oe_n_i(pins.oe_n), .we_n_i(pins.we_n),
		.vid_en_i(pins.vid_en), .addr_i(pins.addr), .dq_i(dq_bus),
		.erase_go_i(erase_go), .dq_o(dev_dq));

	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge pins.we_n) n_wr++;

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic run(input fsc_pkg::fsc_op_t op, input logic [21:0] a,
			input logic [15:0] d, input logic rf);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (busy !== 1'b0 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		w0 = n_wr;
		req_valid = 1;
		req = '{op, a, d};
		@(negedge clk_sys);
		req_valid = 0;
		n = 0;
		// Suspend polling has no limit of its own, so bound it here
		while (done !== 1'b1 && n < 5000) begin
			@(negedge clk_sys);
			n++;
		end
		chk("done", 16'(done), 16'h1);
		chk("busy", 16'(busy), 16'h0);
		chk("refused", 16'(refused), 16'(rf));
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("idle pins", 16'(ctl_pins), 16'h1e);
		resetn = 1;
		run(fsc_pkg::OP_READ, 22'h000123, 16'h0, 0);
		chk("array read", rd_data, 16'h5b79);
		// ----------------------------------------
		// Erase suspend and resume
		// ----------------------------------------
		erase_go = 1;
		run(fsc_pkg::OP_SUSPEND, ES_A, 16'h0, 0);
		chk("suspended", 16'(mode), 16'h8);
		run(fsc_pkg::OP_SUSPEND, ES_A, 16'h0, 0);
		run(fsc_pkg::OP_READ, ES_A, 16'h0, 0);
		s1 = rd_data;
		chk("status", {14'h0, rd_data[7:6]}, 16'h3);
		run(fsc_pkg::OP_READ, ES_A, 16'h0, 0);
		chk("sector toggle", 16'(rd_data[2]), {15'h0, ~s1[2]});
		chk("toggle stopped", 16'(rd_data[6]), 16'(s1[6]));
		run(fsc_pkg::OP_READ, 22'h000123, 16'h0, 0);
		chk("other sector", rd_data, 16'h5b79);
		run(fsc_pkg::OP_PROGRAM, 22'h000200, 16'h1111, 1);
		run(fsc_pkg::OP_RESUME, ES_A, 16'h0, 0);
		chk("resumed", 16'(mode), 16'h0);
		run(fsc_pkg::OP_RESUME, ES_A, 16'h0, 1);
		run(fsc_pkg::OP_SUSPEND, ES_A, 16'h0, 0);
		chk("suspended again", 16'(mode), 16'h8);
		run(fsc_pkg::OP_RESUME, ES_A, 16'h0, 0);
		erase_go = 0;
		$display("test suspend finished");
		// ----------------------------------------
		// Normal and fast programming
		// ----------------------------------------
		run(fsc_pkg::OP_PROGRAM, 22'h000400, 16'h0f0f, 0);
		chk("unlocked writes", 16'(n_wr - w0), 16'h4);
		run(fsc_pkg::OP_FAST_ENTER, 22'h0, 16'h0, 0);
		chk("fast mode", 16'(mode), 16'h4);
		run(fsc_pkg::OP_FAST_PROG, 22'h000300, 16'hbeef, 0);
		chk("fast writes", 16'(n_wr - w0), 16'h2);
		run(fsc_pkg::OP_RESUME, ES_A, 16'h0, 1);
		run(fsc_pkg::OP_READ, 22'h000300, 16'h0, 0);
		chk("fast data", rd_data, 16'hbeef);
		run(fsc_pkg::OP_FAST_EXIT, 22'h000300, 16'h0, 0);
		run(fsc_pkg::OP_READ, 22'h000400, 16'h0, 0);
		chk("program data", rd_data, 16'h0f0f);
		$display("test program finished");
		// ----------------------------------------
		// Group protection under high voltage
		// ----------------------------------------
		run(fsc_pkg::OP_PROTECT, 22'h060000, 16'h0, 0);
		chk("group set", 16'(dev_u.prot[3]), 16'h1);
		chk("no fail", 16'(fail), 16'h0);
		chk("voltage off", 16'(pins.vid_en), 16'h0);
		// Group 7 ignores its first pulse: 60,60,40 then 60,40
		run(fsc_pkg::OP_PROTECT, 22'h0e0000, 16'h0, 0);
		chk("retry writes", 16'(n_wr - w0), 16'h5);
		chk("group retried", 16'(dev_u.prot[7]), 16'h1);
		chk("retry no fail", 16'(fail), 16'h0);
		$display("test protect finished");
		// ----------------------------------------
		// Query table
		// ----------------------------------------
		run(fsc_pkg::OP_QUERY, 22'h0, 16'h0, 0);
		run(fsc_pkg::OP_READ, 22'h000010, 16'h0, 0);
		chk("query word", rd_data, 16'h0041);
		run(fsc_pkg::OP_PROGRAM, 22'h000200, 16'h1, 1);
		run(fsc_pkg::OP_RESET, 22'h0, 16'h0, 0);
		run(fsc_pkg::OP_READ, 22'h000010, 16'h0, 0);
		chk("array again", rd_data, 16'h5a4a);
		$display("test query finished");
		// ----------------------------------------
		// Secure region
		// ----------------------------------------
		run(fsc_pkg::OP_OTP_ENTER, 22'h0, 16'h0, 0);
		run(fsc_pkg::OP_READ, 22'h00007e, 16'h0, 0);
		chk("secure blank", rd_data, 16'hc3bd);
		run(fsc_pkg::OP_OTP_PROG, 22'h00007f, 16'h2468, 0);
		run(fsc_pkg::OP_READ, 22'h00007f, 16'h0, 0);
		chk("secure data", rd_data, 16'h2468);
		dev_u.otp_lock = 1;
		run(fsc_pkg::OP_OTP_PROG, 22'h00007e, 16'h00ff, 0);
		run(fsc_pkg::OP_READ, 22'h00007e, 16'h0, 0);
		chk("secure locked", rd_data, 16'hc3bd);
		run(fsc_pkg::OP_SUSPEND, ES_A, 16'h0, 1);
		run(fsc_pkg::OP_OTP_EXIT, 22'h00007f, 16'h0, 0);
		run(fsc_pkg::OP_READ, 22'h00007f, 16'h0, 0);
		chk("array mapped", rd_data, 16'h5a25);
		run(fsc_pkg::OP_OTP_ENTER, 22'h0, 16'h0, 0);
		resetn = 0;
		@(negedge clk_sys);
		chk("mode after reset", 16'(mode), 16'h0);
		resetn = 1;
		$display("test secure finished");
		end_of_test();
	end
endmodule
`default_nettype wire
